//--- src/snf_pkg.sv
/*
 Shared constants for the serial-to-network framer: register map,
 field positions, reset values, timing and states.
 Assumes a 100 MHz system clock.
*/
package snf_pkg;
    // Register bus shape
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] REG_CTRL     = 8'h00;
    localparam logic [AW-1:0] REG_IDLE_GAP = 8'h04;
    localparam logic [AW-1:0] REG_TX_GAP   = 8'h08;
    localparam logic [AW-1:0] REG_SEP_CFG  = 8'h0c;
    localparam logic [AW-1:0] REG_SEP_PAT  = 8'h10;
    localparam logic [AW-1:0] REG_HWID_LO  = 8'h14;
    localparam logic [AW-1:0] REG_HWID_HI  = 8'h18;
    localparam logic [AW-1:0] REG_STATUS   = 8'h1c;
    localparam logic [AW-1:0] REG_EVT_CNT  = 8'h20;
    // Control bits
    localparam int CTL_W    = 4;
    localparam int CTL_IMM  = 0;
    localparam int CTL_ID   = 1;
    localparam int CTL_LINE = 2;
    localparam int CTL_DUAL = 3;
    // Separator configuration fields
    localparam int SEP_LEN_LSB = 0;
    localparam int SEP_OP_LSB  = 4;
    localparam logic [2:0] SEP_LEN_MAX = 3'h4;
    localparam int SEP_BYTES = 4;
    // Reset values
    localparam logic [7:0]  RST_IDLE_GAP = 8'h0b;
    localparam logic [4:0]  RST_TX_GAP   = 5'h00;
    localparam logic [7:0]  RST_EVT_CNT  = 8'h01;
    // Arbitrary neutral identifier, not tied to any maker
    localparam logic [47:0] RST_HWID = 48'h02_00_00_00_00_01;
    localparam logic [4:0]  TX_GAP_MAX = 5'h19;
    // Packet buffer
    localparam int BUF_AW = 9;
    localparam int CNT_W  = 10;
    localparam logic [CNT_W-1:0] BUF_DEPTH = 10'h200;
    localparam logic [2:0] ID_LAST = 3'h5;
    // Idle gap step: 10 ms at 100 MHz
    localparam int STEP_MS = 10;
    localparam int CLK_KHZ = 100000;
    localparam int STEP_CYC = STEP_MS * CLK_KHZ;
    typedef enum logic [2:0] {
        ST_GATHER, ST_ID, ST_RD, ST_LOAD, ST_OUT
    } snf_state_t;
endpackage

//--- src/snf_mem.sv
/*
 Packet buffer memory: one write port, one read port with
 registered read data. Assumes a single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module snf_mem #(
    parameter int W  = 8,
    parameter int AB = 9
) (
    input  wire logic          mclk,
    input  wire logic          we,
    input  wire logic [AB-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AB-1:0] raddr,
    output var  logic [W-1:0]  rdata_q
);
    logic [W-1:0] mem [0:(1<<AB)-1];

    // Write port
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data one cycle after the address
    always_ff @(posedge mclk) begin
        rdata_q <= mem[raddr];
    end
endmodule
`default_nettype wire

//--- src/snf_pace.sv
/*
 Transmit pacing timer: after each byte handed to the serial
 transmitter, holds busy for gap byte-times. Assumes the byte
 time in clocks comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module snf_pace (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic [4:0]  gap,
    input  wire logic [15:0] byte_cyc,
    output var  logic        busy_q
);
    logic [4:0]  left_q;
    logic [15:0] cyc_q;
    logic [15:0] one_byte;

    // A zero byte time would stall forever, so treat it as one
    assign one_byte = (byte_cyc == 16'h0000) ? 16'h0001 : byte_cyc;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            left_q <= 5'h00;
            cyc_q  <= 16'h0000;
        end else if (start && gap != 5'h00) begin
            busy_q <= 1'b1;
            left_q <= gap;
            cyc_q  <= one_byte;
        end else if (busy_q) begin
            if (cyc_q == 16'h0001) begin
                cyc_q  <= one_byte;
                left_q <= left_q - 5'h01;
                if (left_q == 5'h01) begin
                    busy_q <= 1'b0;
                end
            end else begin
                cyc_q <= cyc_q - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

//--- src/snf_framer.sv
/*
 Serial-to-network framer top: gathers serial bytes into packets,
 paces bytes back to the serial port, sends the identifier on
 connect and relays handshake line changes. Assumes the UART and
 network stack run on mclk; handshake pins are asynchronous.
*/
// The plain strobed port and the placing of the registers were chosen for this implementation.
// Function
// - Received bytes are buffered, not forwarded singly while gathering.
// - Idle gap without new byte closes and hands off the packet.
// - Idle gap zero forwards received data at once.
// - Idle gap counts in ten millisecond steps.
// - Transmit pacing accepts zero to twenty-five; zero is back to back.
// - Pacing unit is one byte time; each byte gets that slot.
// - Separator of zero to four bytes; zero disables it.
// - With separator enabled packets are at most 512 bytes.
// - Separator closes packet with zero, one or two trailing bytes.
// - Immediate forward passes serial data with least delay.
// - Identifier option sends six-byte address after connect, ahead of any waiting packet.
// - Handshake line changes are reported to the peer.
`timescale 1ns/1ps
`default_nettype none
module snf_framer #(
    parameter int STEP_CYCLES = snf_pkg::STEP_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic [snf_pkg::AW-1:0] reg_addr,
    input  wire logic [snf_pkg::DW-1:0] reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [snf_pkg::DW-1:0] reg_rdata,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_data,
    output var  logic                 rx_ready,
    input  wire logic                 conn_up,
    output var  logic                 net_tx_valid,
    output var  logic [7:0]           net_tx_data,
    output var  logic                 net_tx_last,
    input  wire logic                 net_tx_ready,
    input  wire logic                 net_rx_valid,
    input  wire logic [7:0]           net_rx_data,
    output var  logic                 net_rx_ready,
    output var  logic                 ser_tx_valid,
    output var  logic [7:0]           ser_tx_data,
    input  wire logic                 ser_tx_ready,
    input  wire logic [15:0]          byte_cycles,
    input  wire logic [1:0]           hs_pins,
    output var  logic                 line_evt,
    output var  logic [1:0]           line_state,
    input  wire logic                 peer_line_valid,
    input  wire logic [1:0]           peer_line_in,
    output var  logic [1:0]           peer_line
);
    import snf_pkg::*;

    logic [CTL_W-1:0] ctrl_q;
    logic [7:0]  idle_gap_q, evt_cnt_q, drop_q;
    logic [4:0]  tx_gap_q;
    logic [2:0]  sep_len_q;
    logic [1:0]  sep_op_q, tail_q;
    logic [31:0] sep_pat_q, hist_q, hist_d;
    logic [47:0] hwid_q;
    snf_state_t  state_q, state_d;
    logic [CNT_W-1:0]  cnt_q, len_q;
    logic [BUF_AW-1:0] rd_ptr_q;
    logic [2:0]  id_idx_q;
    logic        from_id_q, id_pend_q, conn_q, pend_q;
    logic        rx_take, sep_hit, gap_zero, timeout, close_now;
    logic        full_now, tail_now;
    logic [31:0] step_cnt_q;
    logic [7:0]  steps_q;
    logic [7:0]  mem_rdata;
    logic        pace_busy, tx_hand, net_take;
    logic [1:0]  hs_s1, hs_s2, hs_prev;

    assign rx_take  = rx_valid & rx_ready;
    assign hist_d   = {hist_q[23:0], rx_data};
    assign gap_zero = (idle_gap_q == 8'h00) | ctrl_q[CTL_IMM];
    assign full_now = cnt_q == BUF_DEPTH - 10'h001;
    assign tail_now = tail_q == 2'h1;

    // separator compare over the programmed length
    always_comb begin
        sep_hit = (sep_len_q != 3'h0);
        for (int i = 0; i < SEP_BYTES; i++) begin
            if (i < int'(sep_len_q) &&
                hist_d[8*i +: 8] != sep_pat_q[8*i +: 8]) begin
                sep_hit = 1'b0;
            end
        end
    end

    // close now or after trailing bytes
    assign close_now = rx_take & (gap_zero | full_now | tail_now |
                       (sep_hit & sep_op_q == 2'h0 & tail_q == 2'h0));
    // idle gap expiry; a pending close must not fire it again
    assign timeout = !rx_take && !pend_q && cnt_q != '0 && !gap_zero &&
                     steps_q == idle_gap_q && state_q == ST_GATHER;

    // Register writes; pacing and separator length are clamped
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_q     <= '0;
            idle_gap_q <= RST_IDLE_GAP;
            tx_gap_q   <= RST_TX_GAP;
            sep_len_q  <= 3'h0;
            sep_op_q   <= 2'h0;
            sep_pat_q  <= 32'h0000_0000;
            hwid_q     <= RST_HWID;
            evt_cnt_q  <= RST_EVT_CNT;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: ctrl_q <= reg_wdata[CTL_W-1:0];
                REG_IDLE_GAP: idle_gap_q <= reg_wdata[7:0];
                REG_TX_GAP: tx_gap_q <= (reg_wdata[7:0] > {3'h0, TX_GAP_MAX}) ?
                    TX_GAP_MAX : reg_wdata[4:0];
                REG_SEP_CFG: begin
                    sep_len_q <= (reg_wdata[SEP_LEN_LSB +: 3] >
                        SEP_LEN_MAX) ? SEP_LEN_MAX :
                        reg_wdata[SEP_LEN_LSB +: 3];
                    sep_op_q <= (reg_wdata[SEP_OP_LSB +: 2] == 2'h3) ?
                        2'h2 : reg_wdata[SEP_OP_LSB +: 2];
                end
                REG_SEP_PAT: sep_pat_q <= reg_wdata;
                REG_HWID_LO: hwid_q[31:0] <= reg_wdata;
                REG_HWID_HI: hwid_q[47:32] <= reg_wdata[15:0];
                REG_EVT_CNT: evt_cnt_q <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: reg_rdata <= {28'h0, ctrl_q};
                REG_IDLE_GAP: reg_rdata <= {24'h0, idle_gap_q};
                REG_TX_GAP: reg_rdata <= {27'h0, tx_gap_q};
                REG_SEP_CFG: reg_rdata <= {26'h0, sep_op_q, 1'b0,
                                           sep_len_q};
                REG_SEP_PAT: reg_rdata <= sep_pat_q;
                REG_HWID_LO: reg_rdata <= hwid_q[31:0];
                REG_HWID_HI: reg_rdata <= {16'h0, hwid_q[47:32]};
                REG_STATUS: reg_rdata <= {drop_q, 6'h0, line_state,
                    5'h0, (state_q != ST_GATHER), cnt_q};
                REG_EVT_CNT: reg_rdata <= {24'h0, evt_cnt_q};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // idle timer in steps of STEP_CYCLES
    // restarted per byte, held while empty
    always_ff @(posedge mclk) begin
        if (!nrst || rx_take || cnt_q == '0) begin
            step_cnt_q <= 32'h0;
            steps_q    <= 8'h00;
        end else if (step_cnt_q == 32'(STEP_CYCLES - 1)) begin
            step_cnt_q <= 32'h0;
            if (steps_q != 8'hff) begin
                steps_q <= steps_q + 8'h01;
            end
        end else begin
            step_cnt_q <= step_cnt_q + 32'h1;
        end
    end

    // Packet buffer; read data is registered
    snf_mem #(.W(8), .AB(BUF_AW)) u_mem (
        .mclk    (mclk),
        .we      (rx_take),
        .waddr   (cnt_q[BUF_AW-1:0]),
        .wdata   (rx_data),
        .raddr   (rd_ptr_q),
        .rdata_q (mem_rdata)
    );

    // Next state; a pending identifier goes ahead of a pending packet
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_GATHER: begin
                if (id_pend_q) begin
                    state_d = ST_ID;
                end else if (pend_q) begin
                    state_d = ST_RD;
                end
            end
            ST_ID: state_d = ST_OUT;
            ST_RD: state_d = ST_LOAD;
            ST_LOAD: state_d = ST_OUT;
            ST_OUT: begin
                if (net_tx_ready) begin
                    if (net_tx_last) begin
                        state_d = ST_GATHER;
                    end else if (from_id_q) begin
                        state_d = ST_ID;
                    end else begin
                        state_d = ST_RD;
                    end
                end
            end
            default: state_d = ST_GATHER;
        endcase
    end

    // gather until a close, then drain as one packet
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q  <= ST_GATHER;
            cnt_q    <= '0;
            len_q    <= '0;
            rd_ptr_q <= '0;
            hist_q   <= 32'h0;
            tail_q   <= 2'h0;
            pend_q   <= 1'b0;
            rx_ready <= 1'b0;
        end else begin
            state_q  <= state_d;
            rx_ready <= state_d == ST_GATHER && !pend_q &&
                        !close_now && !timeout && !id_pend_q;
            if (rx_take) begin
                cnt_q  <= cnt_q + 10'h001;
                hist_q <= hist_d;
                if (close_now) begin
                    tail_q <= 2'h0;
                end else if (tail_q != 2'h0) begin
                    tail_q <= tail_q - 2'h1;
                end else if (sep_hit) begin
                    tail_q <= sep_op_q;
                end
            end
            if (close_now || timeout) begin
                pend_q <= 1'b1;
                len_q  <= rx_take ? cnt_q + 10'h001 : cnt_q;
                tail_q <= 2'h0;
                hist_q <= 32'h0;
            end
            if (state_q == ST_GATHER && state_d == ST_RD) begin
                pend_q   <= 1'b0;
                rd_ptr_q <= '0;
            end
            if (state_q == ST_OUT && net_tx_ready && !from_id_q) begin
                if (net_tx_last) begin
                    cnt_q <= '0;
                end else begin
                    rd_ptr_q <= rd_ptr_q + 9'h001;
                end
            end
        end
    end

    // identifier request on each new connection
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            conn_q    <= 1'b0;
            id_pend_q <= 1'b0;
        end else begin
            conn_q <= conn_up;
            if (conn_up && !conn_q && ctrl_q[CTL_ID]) begin
                id_pend_q <= 1'b1;
            end else if (state_q == ST_GATHER) begin
                id_pend_q <= 1'b0;
            end
        end
    end

    // Network output stage, shared by identifier and payload
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            net_tx_valid <= 1'b0;
            net_tx_data  <= 8'h00;
            net_tx_last  <= 1'b0;
            from_id_q    <= 1'b0;
            id_idx_q     <= 3'h0;
        end else begin
            case (state_q)
                ST_GATHER: id_idx_q <= 3'h0;
                ST_ID: begin
                    // Most significant address byte leaves first
                    net_tx_valid <= 1'b1;
                    net_tx_data  <= hwid_q[8*(ID_LAST-id_idx_q) +: 8];
                    net_tx_last  <= id_idx_q == ID_LAST;
                    from_id_q    <= 1'b1;
                    id_idx_q     <= id_idx_q + 3'h1;
                end
                ST_LOAD: begin
                    net_tx_valid <= 1'b1;
                    net_tx_data  <= mem_rdata;
                    net_tx_last  <= {1'b0, rd_ptr_q} == len_q - 10'h001;
                    from_id_q    <= 1'b0;
                end
                ST_OUT: begin
                    if (net_tx_ready) begin
                        net_tx_valid <= 1'b0;
                        net_tx_last  <= 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    // Bytes offered while rx_ready is low are not taken; count those cycles
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            drop_q <= 8'h00;
        end else if (rx_valid && !rx_ready && drop_q != 8'hff) begin
            drop_q <= drop_q + 8'h01;
        end
    end

    // Serial transmit path with pacing
    assign net_take = net_rx_valid & net_rx_ready;
    assign tx_hand  = ser_tx_valid & ser_tx_ready;

    snf_pace u_pace (
        .mclk     (mclk),
        .nrst     (nrst),
        .start    (tx_hand),
        .gap      (tx_gap_q),
        .byte_cyc (byte_cycles),
        .busy_q   (pace_busy)
    );

    // next byte only after the slot ends
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ser_tx_valid <= 1'b0;
            ser_tx_data  <= 8'h00;
            net_rx_ready <= 1'b0;
        end else begin
            if (net_take) begin
                ser_tx_valid <= 1'b1;
                ser_tx_data  <= net_rx_data;
            end else if (tx_hand) begin
                ser_tx_valid <= 1'b0;
            end
            net_rx_ready <= !net_take && !pace_busy && !tx_hand &&
                            !(ser_tx_valid && !ser_tx_ready);
        end
    end

    // Handshake pins are asynchronous: two-stage synchroniser
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hs_s1 <= 2'h0;
            hs_s2 <= 2'h0;
        end else begin
            hs_s1 <= hs_pins;
            hs_s2 <= hs_s1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hs_prev    <= 2'h0;
            line_evt   <= 1'b0;
            line_state <= 2'h0;
            peer_line  <= 2'h0;
        end else begin
            hs_prev    <= hs_s2;
            line_evt   <= ctrl_q[CTL_LINE] && hs_s2 != hs_prev;
            line_state <= hs_s2;
            if (peer_line_valid && ctrl_q[CTL_LINE]) begin
                peer_line <= peer_line_in;
            end
        end
    end

    // Checks
    a_gap_zero_fwd: assert property (@(posedge mclk) disable iff (!nrst)
        rx_take && gap_zero |=> pend_q)
        else $error("immediate close missing");
    a_idle_close: assert property (@(posedge mclk) disable iff (!nrst)
        timeout |=> pend_q && !rx_ready)
        else $error("idle gap did not close packet");
    a_no_single: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == ST_GATHER |-> !net_tx_valid)
        else $error("byte left while gathering");
    a_size_cap: assert property (@(posedge mclk) disable iff (!nrst)
        rx_take && full_now |=> pend_q ##1 cnt_q <= BUF_DEPTH)
        else $error("size cap exceeded");
    a_sep_close: assert property (@(posedge mclk) disable iff (!nrst)
        rx_take && sep_hit && sep_op_q == 2'h0 |=> pend_q)
        else $error("separator did not close");
    a_sep_tail: assert property (@(posedge mclk) disable iff (!nrst)
        rx_take && sep_hit && tail_q == 2'h0 && !close_now
        |=> tail_q == $past(sep_op_q))
        else $error("trailing count wrong");
    a_step_len: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(steps_q != 8'h00) |->
        $past(step_cnt_q) == 32'(STEP_CYCLES - 1))
        else $error("idle step length wrong");
    a_timer_empty: assert property (@(posedge mclk) disable iff (!nrst)
        cnt_q == '0 |=> steps_q == 8'h00)
        else $error("idle timer ran while empty");
    a_id_first: assert property (@(posedge mclk) disable iff (!nrst)
        id_pend_q && state_q == ST_GATHER |=> state_q == ST_ID
        ##1 net_tx_valid && from_id_q)
        else $error("identifier not sent first");
    a_pace_slot: assert property (@(posedge mclk) disable iff (!nrst)
        tx_hand && tx_gap_q != 5'h00 |=> pace_busy ##1 !net_rx_ready)
        else $error("pacing slot not held");
    a_line_evt: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_q[CTL_LINE] && hs_s2 != hs_prev |=> line_evt)
        else $error("line change not reported");
    c_packet: cover property (@(posedge mclk) disable iff (!nrst)
        net_tx_valid && net_tx_last && net_tx_ready && !from_id_q);
    c_ident: cover property (@(posedge mclk) disable iff (!nrst)
        net_tx_valid && from_id_q && net_tx_last);
    c_tail: cover property (@(posedge mclk) disable iff (!nrst)
        rx_take && tail_now);
    c_line: cover property (@(posedge mclk) disable iff (!nrst)
        line_evt);
endmodule
`default_nettype wire

//--- tb/snf_peer.sv
/*
 Far-side model: network sink and serial transmitter sink.
 Assumes the framer's clock; stalls at random while slow is high.
*/
`timescale 1ns/1ps
`default_nettype none
module snf_peer (
    input  wire logic mclk,
    input  wire logic slow,
    output var  logic net_tx_ready = 1'b0,
    output var  logic ser_tx_ready = 1'b0
);
    // Random stalls stretch every hold that the framer must keep
    always @(posedge mclk) begin
        net_tx_ready <= !slow || 1'($urandom_range(1));
        ser_tx_ready <= !slow || 1'($urandom_range(1));
    end
endmodule
`default_nettype wire

//--- tb/snf_framer_bench.sv
/*
 Self-checking bench for the framer: registers, packet closing,
 identifier, pacing and line relay. Assumes snf_pkg and snf_peer.
*/
`timescale 1ns/1ps
`default_nettype none
module snf_framer_bench;
    import snf_pkg::*;
    localparam int STEP = 20;
    logic          mclk = 0, nrst = 0, rx_valid = 0, conn_up = 0, slow = 0;
    logic          reg_wr = 0, reg_rd = 0, net_rx_valid = 0;
    logic          peer_line_valid = 0;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0, reg_rdata;
    logic [7:0]    rx_data = '0, net_rx_data = '0, net_tx_data, ser_tx_data;
    logic [15:0]   byte_cycles = 16'h0005;
    logic [1:0]    hs_pins = '0, peer_line_in = '0, line_state, peer_line;
    logic          rx_ready, net_tx_valid, net_tx_last, net_tx_ready;
    logic          net_rx_ready, ser_tx_valid, ser_tx_ready, line_evt;
    logic [8:0]    nq[$];
    logic [7:0]    sq[$];
    int            err_count = 0, compares = 0, last_t = 0, cyc = 0;

    snf_framer #(.STEP_CYCLES(STEP)) dut_u (.mclk, .nrst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_data,
        .rx_ready, .conn_up, .net_tx_valid, .net_tx_data, .net_tx_last,
        .net_tx_ready, .net_rx_valid, .net_rx_data, .net_rx_ready,
        .ser_tx_valid, .ser_tx_data, .ser_tx_ready, .byte_cycles, .hs_pins,
        .line_evt, .line_state, .peer_line_valid, .peer_line_in, .peer_line);
    snf_peer peer_u (.mclk, .slow, .net_tx_ready, .ser_tx_ready);

    // Free-running system clock
    always #5 mclk = ~mclk;

    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
        @(posedge mclk);
    endtask

    // Valid stays up between bytes; the caller lowers it after a burst
    task automatic rx(logic [7:0] d, logic last);
        nq.push_back({last, d});
        rx_valid <= 1'b1;
        rx_data <= d;
        do @(posedge mclk); while (rx_ready !== 1'b1);
    endtask

    task automatic tx(logic [7:0] d);
        sq.push_back(d);
        net_rx_valid <= 1'b1;
        net_rx_data <= d;
        do @(posedge mclk); while (net_rx_ready !== 1'b1);
        net_rx_valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic drain();
        rx_valid <= 1'b0;
        repeat (3000) if (nq.size() + sq.size() > 0) @(posedge mclk);
        chk("pending", 0, nq.size() + sq.size());
        repeat (4) @(posedge mclk);
    endtask

    // Each accepted byte is matched against the oldest note
    always @(posedge mclk) begin
        cyc++;
        if (net_tx_valid === 1'b1 && net_tx_ready === 1'b1)
            chk("net_tx", nq.size() ? nq.pop_front() : 9'bx,
                {net_tx_last, net_tx_data});
        if (ser_tx_valid === 1'b1 && ser_tx_ready === 1'b1) begin
            chk("ser_tx", sq.size() ? sq.pop_front() : 8'bx, ser_tx_data);
            if (last_t > 0 && cyc - last_t < 2 * 5)
                chk("pace_slot", 1, 0);
            last_t = cyc;
        end
    end

    // Watchdog sized well above the expected run
    initial begin
        #300000;
        err_count++;
        conclude();
    end

    initial begin
        void'($urandom(4));
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(REG_IDLE_GAP, 32'h0000000b);
        rd(REG_EVT_CNT, 32'h00000001);
        rd(8'h3c, 32'h00000000);
        wr(REG_TX_GAP, 32'h0000001f);
        rd(REG_TX_GAP, 32'h00000019);
        // Immediate forward with a live gap, then a zero gap alone
        for (int m = 0; m < 2; m++) begin
            wr(REG_IDLE_GAP, m ? 32'h00000000 : 32'h00000002);
            wr(REG_CTRL, 32'(1 - m));
            rx(8'($urandom), 1'b1);
            rx_valid <= 1'b0;
            repeat (10) @(posedge mclk);
            chk("fast_close", 0, nq.size());
        end
        // Gaps just under the timeout only pass if each byte restarts it
        wr(REG_IDLE_GAP, 32'h00000002);
        for (int i = 0; i < 3; i++) begin
            rx(8'($urandom), i == 2);
            rx_valid <= 1'b0;
            repeat (i < 2 ? 30 : 35) @(posedge mclk);
        end
        chk("early_close", 0, nq.size() == 0);
        repeat (20) @(posedge mclk);
        chk("idle_close", 0, nq.size());
        drain();
        wr(REG_IDLE_GAP, 32'h00000040);
        wr(REG_SEP_PAT, 32'h00000d0a);
        for (int op = 0; op < 3; op++) begin
            wr(REG_SEP_CFG, 32'(op * 16 + 2));
            rx(8'h41, 1'b0);
            rx(8'h0d, 1'b0);
            rx(8'h0a, op == 0);
            for (int k = 1; k <= op; k++)
                rx(8'(48 + k), k == op);
            drain();
        end
        // Size limit with stalls on the network side
        wr(REG_SEP_CFG, 32'h00000000);
        slow <= 1'b1;
        for (int i = 0; i < 512; i++)
            rx(8'($urandom), i == 511);
        drain();
        for (int i = 0; i < 6; i++)
            nq.push_back({i == 5, RST_HWID[47 - 8 * i -: 8]});
        wr(REG_CTRL, 32'h00000002);
        conn_up <= 1'b1;
        drain();
        wr(REG_CTRL, 32'h00000004);
        hs_pins <= 2'b10;
        repeat (10) begin
            @(posedge mclk);
            if (line_evt === 1'b1)
                break;
        end
        chk("line_evt", 1, line_evt);
        chk("line_state", 2, line_state);
        peer_line_in <= 2'b01;
        peer_line_valid <= 1'b1;
        @(posedge mclk);
        peer_line_valid <= 1'b0;
        #1 chk("peer_line", 1, peer_line);
        wr(REG_TX_GAP, 32'h00000002);
        for (int i = 0; i < 3; i++)
            tx(8'($urandom));
        drain();
        conclude();
    end
endmodule
`default_nettype wire
